// file: tb_top.sv
// Bench joining controller and counter, binary and decade pairs
`timescale 1ns/10ps
`include "udc_regs.svh"
module tb_top;
	typedef struct
	{
		logic [3:0] v, eb, ed;
		logic d, mb, md;
		int n;
	} udc_row_s;
	udc_row_s rows [7] = '{
		'{4'hd, 4'h2, 4'h2, 1'h0, 1'h0, 1'h0, 5},
		'{4'h7, 4'hc, 4'h2, 1'h0, 1'h0, 1'h0, 5},
		'{4'h2, 4'hd, 4'h7, 1'h1, 1'h0, 1'h0, 5},
		'{4'h0, 4'hf, 4'h9, 1'h1, 1'h0, 1'h0, 1},
		'{4'he, 4'hf, 4'hf, 1'h0, 1'h1, 1'h0, 1},
		'{4'h1, 4'h0, 4'h0, 1'h1, 1'h1, 1'h1, 1},
		'{4'h8, 4'h9, 4'h9, 1'h0, 1'h0, 1'h1, 1}};
	logic clock = 1'h0;
	logic srst = 1'h1;
	logic run = 1'h0;
	logic dn = 1'h0;
	logic ld = 1'h0;
	logic [3:0] lv = 4'h0;
	logic [3:0] cb, cd;
	logic mb, md, cas, busy;
	logic [3:0] cs;
	logic ms, csn;
	int w;
	int mismatches = 0;
	int checked = 0;
	int k;
	udc_if bin_if ();
	udc_if dec_if ();
	udc_ctrl udc_ctrl_inst (.clock(clock), .srst(srst), .pins(bin_if.ctl), .run(run),
		.down_req(dn), .load_req(ld), .load_value(lv), .count_seen(cs),
		.max_min_seen(ms), .cascade_seen_n(csn), .busy(busy));
	udc_ctrl udc_ctrl_inst2 (.clock(clock), .srst(srst), .pins(dec_if.ctl), .run(run),
		.down_req(dn), .load_req(ld), .load_value(lv), .count_seen(),
		.max_min_seen(), .cascade_seen_n(), .busy());
	udc_counter #(.DECADE(1'h0)) udc_counter_inst (.clock(clock), .srst(srst),
		.pins(bin_if.dev), .count_out(cb), .max_min_out(mb), .cascade_clock_out_n(cas));
	udc_counter #(.DECADE(1'h1)) udc_counter_inst2 (.clock(clock), .srst(srst),
		.pins(dec_if.dev), .count_out(cd), .max_min_out(md), .cascade_clock_out_n());
	udc_asserts udc_asserts_inst (.clock(clock), .srst(srst), .count_clk(bin_if.count_clk),
		.inhibit(bin_if.inhibit), .down(bin_if.down), .load_n(bin_if.load_n),
		.data(bin_if.data), .count(bin_if.count), .max_min(bin_if.max_min),
		.cascade_clock_out_n(bin_if.cascade_clock_out_n));
	////////////////////////////////
	task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		cmp4({3'h0, got}, {3'h0, exp});
	endtask
	// Second request lands while busy, so it must be dropped
	task automatic do_load(input logic [3:0] v, input logic [3:0] w);
		lv = v;
		ld = 1'h1;
		@(negedge clock);
		ld = 1'h0;
		@(negedge clock);
		lv = w;
		ld = 1'h1;
		@(negedge clock);
		ld = 1'h0;
		k = 0;
		while (busy !== 1'h0 && k < 99)
		begin
			@(negedge clock);
			k++;
		end
		// A hung load counts as a failure
		if (k == 99)
			mismatches++;
	endtask
	task automatic steps(input int n);
		logic [3:0] p;
		repeat (n)
		begin
			p = cb;
			k = 0;
			while (cb === p && k < 99)
			begin
				@(negedge clock);
				k++;
			end
			if (k == 99)
				mismatches++;
		end
	endtask
	task automatic final_report;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////
	always #2 clock = ~clock;
	initial
	begin
		// Whole run is near 2 us; generous margin
		#20000;
		mismatches++;
		final_report;
	end
	initial
	begin
		repeat (12) @(negedge clock);
		srst = 1'h0;
		foreach (rows[i])
		begin
			dn = rows[i].d;
			do_load(rows[i].v, ~rows[i].v);
			cmp4(cb, rows[i].v);
			run = 1'h1;
			steps(rows[i].n);
			run = 1'h0;
			repeat (12) @(negedge clock);
			cmp4(cb, rows[i].eb);
			cmp4(cd, rows[i].ed);
			cmp1(mb, rows[i].mb);
			cmp1(md, rows[i].md);
			cmp4(cs, rows[i].eb);
			cmp1(ms, rows[i].mb);
			$display("row %0d done", i);
		end
		run = 1'h1;
		do_load(4'h5, 4'h9);
		cmp4(cd, 4'h5);
		run = 1'h0;
		$display("load test done");
		// Park at fifteen counting up and watch one carry pulse
		run = 1'h1;
		dn = 1'h0;
		do_load(4'hf, 4'h3);
		k = 0;
		while (cas !== 1'h0 && k < 99)
		begin
			@(negedge clock);
			k++;
		end
		if (k == 99)
			mismatches++;
		cmp4(cb, 4'hf);
		cmp1(mb, 1'h1);
		w = 0;
		while (cas === 1'h0 && w < 99)
		begin
			@(negedge clock);
			w++;
		end
		cmp4(4'(w), 4'(`UDC_HALF_CYC));
		cmp4(cb, 4'h0);
		cmp1(mb, 1'h0);
		cmp1(csn, 1'h0);
		run = 1'h0;
		$display("cascade test done");
		repeat (20) @(negedge clock);
		srst = 1'h1;
		repeat (3) @(negedge clock);
		srst = 1'h0;
		repeat (12) @(negedge clock);
		cmp4(cb, 4'h0);
		cmp1(mb, 1'h0);
		cmp1(cas, 1'h1);
		cmp1(csn, 1'h1);
		$display("reset test done");
		final_report;
	end
endmodule

// file: udc_asserts.sv
// Pin checks between the controller and the binary counter
`timescale 1ns/10ps
`include "udc_regs.svh"
module udc_asserts
(
	input logic clock,
	input logic srst,
	input logic count_clk,
	input logic inhibit,
	input logic down,
	input logic load_n,
	input logic [`UDC_CNT_W-1:0] data,
	input logic [`UDC_CNT_W-1:0] count,
	input logic max_min,
	input logic cascade_clock_out_n
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (srst);
	////////////////////////////////
	// Binary limits only; decade limits are judged by the bench
	step_up_a:
	assert property ($rose(count_clk) && !inhibit && load_n && !down
		|=> count == $past(count) + `UDC_ONE) else $error("no up step");
	step_down_a:
	assert property ($rose(count_clk) && !inhibit && load_n && down
		|=> count == $past(count) - `UDC_ONE) else $error("no down step");
	count_hold_a:
	assert property (load_n && !($rose(count_clk) && !inhibit) |=> $stable(count))
		else $error("count moved");
	load_copy_a:
	assert property (!load_n |=> count == $past(data)) else $error("load missed");
	term_flag_a:
	assert property (!$past(srst) |-> max_min == ($past(down) ? count == `UDC_MIN_VAL
		: count == `UDC_BIN_MAX)) else $error("terminal flag wrong");
	casc_gate_a:
	assert property (!cascade_clock_out_n |-> !$past(count_clk) && !$past(inhibit)
		&& $past(load_n)) else $error("stray cascade pulse");
	inhib_edge_a:
	assert property (!$past(srst) && $changed(inhibit) |-> count_clk && $past(count_clk))
		else $error("inhibit moved in low phase");
	load_clk_a:
	assert property (!load_n |-> count_clk) else $error("load with clock low");
	casc_fire_a:
	assert property (!count_clk && !inhibit && load_n && (down ? count == `UDC_MIN_VAL
		: count == `UDC_BIN_MAX) |=> !cascade_clock_out_n) else $error("cascade pulse missing");
	down_edge_a:
	assert property (!$past(srst) && $changed(down) |-> count_clk && $past(count_clk))
		else $error("direction moved in low phase");
endmodule

// file: udc_counter.sv
// Reversible 4-bit counter, binary or decade, device end of the link
`timescale 1ns/10ps
`include "udc_regs.svh"
module udc_counter
#(
	parameter bit DECADE = 1'b0
)
(
	input wire logic clock,
	input wire logic srst,
	udc_if.dev pins,
	output logic [`UDC_CNT_W-1:0] count_out,
	output logic max_min_out,
	output logic cascade_clock_out_n
);
	////////////////////////////////////////////////////////////////////////////

	udc_pkg::udc_dev_s r;
	udc_pkg::udc_dev_s next_r;
	udc_pkg::udc_value_t step_value;
	udc_pkg::udc_value_t top_value;
	logic count_edge;
	logic next_terminal;

	////////////////////////////////////////////////////////////////////////////

	// Count clock is a plain pin sampled on the system clock
	assign count_edge = pins.count_clk & ~r.clk_q;

	// Decade keeps a BCD digit, binary the full nibble
	assign top_value = DECADE ? `UDC_DEC_MAX : `UDC_BIN_MAX;

	udc_step u_step
	(
		.value(r.count),
		.down(pins.down),
		.decade(DECADE),
		.next_value(step_value)
	);

	////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		next_r = r;
		next_r.clk_q = pins.count_clk;

		// Load wins over any clock edge, whatever the clock level
		if (!pins.load_n)
			next_r.count = pins.data;
		else if (count_edge && !pins.inhibit)
			next_r.count = step_value;
		else
			next_r.count = r.count;

		// Terminal state depends on direction: max going up, min going down
		if (pins.down)
			next_terminal = (next_r.count == `UDC_MIN_VAL);
		else
			next_terminal = (next_r.count == top_value);
		next_r.max_min = next_terminal;

		// Low only in the clock low phase of an enabled terminal count;
		// gating with load keeps a preset from sending a false carry
		next_r.casc_n = ~(next_terminal & ~pins.inhibit & ~pins.count_clk
			& pins.load_n);
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			r.count <= `UDC_MIN_VAL;
			// Count clock idles high; a low here would fake an edge after reset
			r.clk_q <= 1'b1;
			r.max_min <= 1'b0;
			r.casc_n <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	// Outputs come straight from the state flops
	assign pins.count = r.count;
	assign pins.max_min = r.max_min;
	assign pins.cascade_clock_out_n = r.casc_n;
	assign count_out = r.count;
	assign max_min_out = r.max_min;
	assign cascade_clock_out_n = r.casc_n;
endmodule

// file: udc_ctrl.sv
// Controlling logic that drives the counter pins from user requests
`timescale 1ns/10ps
`include "udc_regs.svh"
module udc_ctrl
(
	input wire logic clock,
	input wire logic srst,
	udc_if.ctl pins,
	input wire logic run,
	input wire logic down_req,
	input wire logic load_req,
	input wire logic [`UDC_CNT_W-1:0] load_value,
	output logic [`UDC_CNT_W-1:0] count_seen,
	output logic max_min_seen,
	output logic cascade_seen_n,
	output logic busy
);
	////////////////////////////////////////////////////////////////////////////

	localparam udc_pkg::udc_cnt_t HALF_LAST = udc_pkg::udc_cnt_t'(`UDC_HALF_CYC - 1);
	localparam udc_pkg::udc_cnt_t LOAD_LAST = udc_pkg::udc_cnt_t'(`UDC_LOAD_CYC - 1);

	udc_pkg::udc_ctl_s r;
	udc_pkg::udc_ctl_s next_r;
	logic div_end;

	assign div_end = (r.div == HALF_LAST);

	////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		next_r = r;

		// Count clock divider; outside RUN the clock parks high so a
		// load never meets a low clock with low inhibit
		if (div_end)
		begin
			next_r.div = `UDC_DIV_ZERO;
			if (r.state == udc_pkg::UDC_RUN || !r.cclk)
				next_r.cclk = ~r.cclk;
		end
		else
		begin
			next_r.div = r.div + udc_pkg::udc_cnt_t'(1);
		end

		// Control levels move only inside a high phase that stays high
		if (r.cclk && next_r.cclk)
		begin
			next_r.inhibit = ~run;
			next_r.down = down_req;
		end

		unique case (r.state)
			udc_pkg::UDC_RUN:
			begin
				if (load_req)
				begin
					next_r.data = load_value;
					next_r.state = udc_pkg::UDC_PREP;
				end
			end
			udc_pkg::UDC_PREP:
			begin
				if (r.cclk && next_r.cclk)
				begin
					next_r.load_n = 1'b0;
					next_r.lcnt = LOAD_LAST;
					next_r.state = udc_pkg::UDC_LOAD;
				end
			end
			udc_pkg::UDC_LOAD:
			begin
				if (r.lcnt == `UDC_LCNT_ZERO)
				begin
					next_r.load_n = 1'b1;
					next_r.state = udc_pkg::UDC_REL;
				end
				else
				begin
					next_r.lcnt = r.lcnt - udc_pkg::udc_cnt_t'(1);
				end
			end
			udc_pkg::UDC_REL:
			begin
				next_r.state = udc_pkg::UDC_RUN;
			end
		endcase

		next_r.busy = (next_r.state != udc_pkg::UDC_RUN);
		next_r.count_seen = pins.count;
		next_r.max_min_seen = pins.max_min;
		next_r.casc_seen_n = pins.cascade_clock_out_n;
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			r.state <= udc_pkg::UDC_RUN;
			r.div <= `UDC_DIV_ZERO;
			r.lcnt <= `UDC_LCNT_ZERO;
			r.cclk <= 1'b1;
			r.inhibit <= 1'b1;
			r.down <= 1'b0;
			r.load_n <= 1'b1;
			r.data <= `UDC_MIN_VAL;
			r.count_seen <= `UDC_MIN_VAL;
			r.max_min_seen <= 1'b0;
			r.casc_seen_n <= 1'b1;
			r.busy <= 1'b0;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign pins.count_clk = r.cclk;
	assign pins.inhibit = r.inhibit;
	assign pins.down = r.down;
	assign pins.load_n = r.load_n;
	assign pins.data = r.data;
	assign count_seen = r.count_seen;
	assign max_min_seen = r.max_min_seen;
	assign cascade_seen_n = r.casc_seen_n;
	assign busy = r.busy;
endmodule

// file: udc_if.sv
// Pin bundle between the counter and the controlling logic
`timescale 1ns/10ps
`include "udc_regs.svh"
interface udc_if;
	logic count_clk;
	logic inhibit;
	logic down;
	logic load_n;
	logic [`UDC_CNT_W-1:0] data;
	logic [`UDC_CNT_W-1:0] count;
	logic max_min;
	logic cascade_clock_out_n;

	modport dev
	(
		input count_clk,
		input inhibit,
		input down,
		input load_n,
		input data,
		output count,
		output max_min,
		output cascade_clock_out_n
	);

	modport ctl
	(
		output count_clk,
		output inhibit,
		output down,
		output load_n,
		output data,
		input count,
		input max_min,
		input cascade_clock_out_n
	);
endinterface

// file: udc_pkg.sv
// Types shared by the counter and its controller
`include "udc_regs.svh"
package udc_pkg;
	typedef logic [`UDC_CNT_W-1:0] udc_value_t;
	typedef logic [`UDC_DIV_W-1:0] udc_cnt_t;

	typedef enum logic [1:0]
	{
		UDC_RUN = 2'h0,
		UDC_PREP = 2'h1,
		UDC_LOAD = 2'h3,
		UDC_REL = 2'h2
	} udc_state_e;

	typedef struct packed
	{
		udc_value_t count;
		logic clk_q;
		logic max_min;
		logic casc_n;
	} udc_dev_s;

	typedef struct packed
	{
		udc_state_e state;
		udc_cnt_t div;
		udc_cnt_t lcnt;
		logic cclk;
		logic inhibit;
		logic down;
		logic load_n;
		udc_value_t data;
		udc_value_t count_seen;
		logic max_min_seen;
		logic casc_seen_n;
		logic busy;
	} udc_ctl_s;
endpackage

// file: udc_regs.svh
// Constants for the reversible 4-bit counter and its controller
// Summary of operation
// - All four count bits update together
// - Count one step per enabled rising edge
// - Inhibit high holds the present count
// - Controller changes inhibit only while clock high
// - Direction low counts up, high down
// - Controller changes direction only while clock high
// - Controller avoids low clock/inhibit during load
// - Load low copies data inputs, overriding counting
// - Binary holds four bits, decade BCD 8-4-2-1
// - Binary wraps fifteen-zero both directions
// - Decade wraps nine-zero both directions
// - Terminal flag high at max up, min down
// - Cascade clock pulses low during clock low
// - Cascade clock feeds next inhibit or clock
// - Terminal flag usable for look-ahead carry
`ifndef UDC_REGS_SVH
`define UDC_REGS_SVH

`define UDC_CNT_W 4
`define UDC_MIN_VAL 4'h0
`define UDC_BIN_MAX 4'hf
`define UDC_DEC_MAX 4'h9
`define UDC_ONE 4'h1
`define UDC_CLK_PERIOD_NS 4
`define UDC_HALF_NS 20
`define UDC_HALF_CYC ((`UDC_HALF_NS + `UDC_CLK_PERIOD_NS - 1) / `UDC_CLK_PERIOD_NS)
`define UDC_LOAD_NS 35
`define UDC_LOAD_CYC ((`UDC_LOAD_NS + `UDC_CLK_PERIOD_NS - 1) / `UDC_CLK_PERIOD_NS)
`define UDC_DIV_W 8
`define UDC_DIV_ZERO 8'h00
`define UDC_LCNT_ZERO 8'h00

`endif

// file: udc_step.sv
// Next-value arithmetic for one count step, binary or decade
`timescale 1ns/10ps
`include "udc_regs.svh"
module udc_step
(
	input wire logic [`UDC_CNT_W-1:0] value,
	input wire logic down,
	input wire logic decade,
	output logic [`UDC_CNT_W-1:0] next_value
);
	always_comb
	begin
		if (!down)
		begin
			if (decade && value == `UDC_DEC_MAX)
				next_value = `UDC_MIN_VAL;
			else
				next_value = value + `UDC_ONE;
		end
		else
		begin
			if (decade && value == `UDC_MIN_VAL)
				next_value = `UDC_DEC_MAX;
			else
				next_value = value - `UDC_ONE;
		end
	end
endmodule
